// file: logic/ccs_defines.svh
// Register offsets, setup word layout, reset values and counts
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
`define CCS_ADDR_SETUP 8'h00
`define CCS_ADDR_CTRL 8'h04
`define CCS_ADDR_C0 8'h08
`define CCS_ADDR_C1 8'h0c
`define CCS_ADDR_TQTY 8'h10
`define CCS_ADDR_RAW 8'h14
`define CCS_ADDR_TEMP 8'h18
`define CCS_ADDR_STAT 8'h1c
`define CCS_ADDR_MASK 8'h20
`define CCS_ADDR_TCAL 8'h24
`define CCS_ZS_LSB 0
`define CCS_REF_LSB 3
`define CCS_RS_LSB 6
`define CCS_DIFF_BIT 8
`define CCS_RES_LSB 9
`define CCS_PDM_BIT 11
`define CCS_SETUP_RST 12'h638
`define CCS_CMULT1 14'h0090
`define CCS_CMULT2 14'h0240
`define CCS_CMULT4 14'h0900
`define CCS_CMULT8 14'h2400
`define CCS_CONV_PERIODS 4'h4
`define CCS_ST_CAP 0
`define CCS_ST_TEMP 1
`define CCS_ST_LO 2
`define CCS_ST_HI 3
`endif

// file: logic/ccs_pkg.sv
// Types shared by the converter setup block
package ccs_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SAMPLE = 5'h02,
    ST_CALC = 5'h04,
    ST_DIV = 5'h08,
    ST_DONE = 5'h10
  } ccs_state_t;
endpackage

// file: logic/ccs_excite.sv
// Excitation square wave divided from the system clock by range
`timescale 1ns/10ps
module ccs_excite (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] range_sel,
  output logic exc,
  output logic tick
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] low_mask;

  always_comb begin
    next_cnt = cnt + 4'h1;
    case (range_sel)
      2'h0: low_mask = 4'h1;
      2'h1: low_mask = 4'h3;
      2'h2: low_mask = 4'h7;
      default: low_mask = 4'hf;
    endcase
  end

  // Divide by 2, 4, 8 or 16: bit rs of a free counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= 4'h0;
      exc <= 1'b0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      exc <= next_cnt[range_sel];
      tick <= (next_cnt & low_mask) == 4'h0;
    end
  end

  // A range change at a conversion start breaks one period, so only a settled range is checked
  property p_div2;
    @(posedge clk) disable iff (!rstn)
    (range_sel == 2'h0 && $stable(range_sel)) |=> (exc != $past(exc));
  endproperty
  a_div2: assert property (p_div2) else $error("mult1 excitation not clk/2");

  property p_div16;
    @(posedge clk) disable iff (!rstn)
    ($rose(exc) && range_sel == 2'h3 && $stable(range_sel)) |=>
      (exc || range_sel != 2'h3)[*7] ##1 (!exc || range_sel != 2'h3);
  endproperty
  a_div16: assert property (p_div16) else $error("mult8 half period not 8");
endmodule

// file: logic/ccs_divider.sv
// Iterative restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module ccs_divider (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [16:0] divisor,
  output logic done,
  output logic [31:0] quotient
);
  logic [17:0] rem;
  logic [5:0] cnt;
  logic busy;
  logic [17:0] trial;

  assign trial = {rem[16:0], quotient[31]};

  // A zero divisor yields all ones, which the caller clamps to full scale
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rem <= 18'h0;
      cnt <= 6'h0;
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= 32'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rem <= 18'h0;
        cnt <= 6'h0;
        busy <= 1'b1;
        quotient <= dividend;
      end else if (busy) begin
        if (trial >= {1'b0, divisor}) begin
          rem <= trial - {1'b0, divisor};
          quotient <= {quotient[30:0], 1'b1};
        end else begin
          rem <= trial;
          quotient <= {quotient[30:0], 1'b0};
        end
        cnt <= cnt + 6'h1;
        if (cnt == 6'h1f) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  property p_latency;
    @(posedge clk) disable iff (!rstn)
    start |-> ##33 done;
  endproperty
  a_latency: assert property (p_latency) else $error("divider latency not 33");
endmodule

// file: logic/ccs_top.sv
// Converter setup decode, ratio scaling and APB register file
// What this block does
// - Raw code equals sensor ratio times two to result width 8, 10, 12, 14.
// - Ratio valid from zero to one, code spans zero to full scale.
// - Single-ended reference capacitance set by 3-bit trim and 2-bit range.
// - Subtract offset of range scale times zero-shift trim times 1 pF.
// - Single-ended output is sensor minus offset over internal reference, or over C1 when trim is 0.
// - Input mux chooses capacitance or temperature for each conversion.
// - Temperature measurement calibrated and delivered fourteen bits wide.
// - Reference driven with square wave at the selected range frequency.
// - All converter settings come from the nonvolatile setup word.
// - Conversion-complete output shares its pad with capacitance density out.
// - Excitation is clock over 2, 4, 8, 16 for factors 1, 2, 4, 8.
// - Range codes 00..11 give factors 1..8, scale 1.44 up to 92.16.
`timescale 1ns/10ps
`include "ccs_defines.svh"
module ccs_top import ccs_pkg::*; (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic EXC_OUT,
  output logic READY_PDM
);
  logic [11:0] setup_word;
  logic [11:0] active;
  logic [15:0] sense_c0;
  logic [15:0] sense_c1;
  logic [15:0] temp_qty;
  logic [15:0] temp_cal;
  logic [13:0] raw_capacitance_code;
  logic [13:0] temp_reading;
  logic [3:0] status;
  logic [3:0] mask;
  logic meas_temp;
  logic ready_flag;
  ccs_state_t state;
  logic [3:0] per_cnt;
  logic [17:0] numer;
  logic [16:0] denom;
  logic div_start;
  logic div_done;
  logic [31:0] div_q;
  logic exc;
  logic exc_tick;
  logic setup_phase;
  logic access;
  logic wr;
  logic start_cap;
  logic start_temp;
  logic [3:0] stat_set;
  logic [2:0] zs;
  logic [2:0] rf;
  logic [1:0] rs;
  logic diff;
  logic [1:0] resw;
  logic [16:0] next_coff;
  logic [16:0] next_den;
  logic [17:0] next_num;
  logic [4:0] next_shift;
  logic [31:0] next_dividend;
  logic [13:0] next_code;
  logic [13:0] next_temp;
  logic next_lo;
  logic next_hi;
  logic [13:0] fs;
  logic [16:0] tsum;
  logic [13:0] dens_in;
  logic [14:0] dens_acc;
  logic dens_bit;

  function automatic logic [16:0] cap_scale(input logic [1:0] r, input logic [2:0] t);
    logic [13:0] cm;
    case (r)
      2'h0: cm = `CCS_CMULT1;
      2'h1: cm = `CCS_CMULT2;
      2'h2: cm = `CCS_CMULT4;
      default: cm = `CCS_CMULT8;
    endcase
    cap_scale = {3'h0, cm} * {14'h0, t};
  endfunction

  function automatic logic [13:0] full_scale(input logic [1:0] w);
    case (w)
      2'h0: full_scale = 14'h00ff;
      2'h1: full_scale = 14'h03ff;
      2'h2: full_scale = 14'h0fff;
      default: full_scale = 14'h3fff;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      `CCS_ADDR_SETUP, `CCS_ADDR_CTRL, `CCS_ADDR_C0, `CCS_ADDR_C1,
      `CCS_ADDR_TQTY, `CCS_ADDR_RAW, `CCS_ADDR_TEMP, `CCS_ADDR_STAT,
      `CCS_ADDR_MASK, `CCS_ADDR_TCAL: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  assign zs = active[`CCS_ZS_LSB +: 3];
  assign rf = active[`CCS_REF_LSB +: 3];
  assign rs = active[`CCS_RS_LSB +: 2];
  assign diff = active[`CCS_DIFF_BIT];
  assign resw = active[`CCS_RES_LSB +: 2];
  assign setup_phase = PSEL & PENABLE & ~PREADY;
  assign access = PSEL & PENABLE & PREADY;
  assign wr = access & PWRITE & reg_hit(PADDR);
  assign start_cap = wr && PADDR == `CCS_ADDR_CTRL && PWDATA[0];
  assign start_temp = wr && PADDR == `CCS_ADDR_CTRL && PWDATA[1] && !PWDATA[0];

  // One wait state: answer comes the cycle after penable rises
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else begin
      PREADY <= setup_phase;
      PSLVERR <= setup_phase & ~reg_hit(PADDR);
      PRDATA <= 32'h0;
      if (setup_phase && !PWRITE) begin
        case (PADDR)
          `CCS_ADDR_SETUP: PRDATA <= {20'h0, setup_word};
          `CCS_ADDR_CTRL: PRDATA <= {31'h0, state != ST_IDLE};
          `CCS_ADDR_C0: PRDATA <= {16'h0, sense_c0};
          `CCS_ADDR_C1: PRDATA <= {16'h0, sense_c1};
          `CCS_ADDR_TQTY: PRDATA <= {16'h0, temp_qty};
          `CCS_ADDR_RAW: PRDATA <= {18'h0, raw_capacitance_code};
          `CCS_ADDR_TEMP: PRDATA <= {18'h0, temp_reading};
          `CCS_ADDR_STAT: PRDATA <= {28'h0, status};
          `CCS_ADDR_MASK: PRDATA <= {28'h0, mask};
          `CCS_ADDR_TCAL: PRDATA <= {16'h0, temp_cal};
          default: PRDATA <= 32'h0;
        endcase
      end
    end
  end

  // Setup word stands in for the nonvolatile store; sample values model the front end
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      setup_word <= `CCS_SETUP_RST;
      sense_c0 <= 16'h0;
      sense_c1 <= 16'h0;
      temp_qty <= 16'h0;
      temp_cal <= 16'h0;
      mask <= 4'h0;
    end else if (wr) begin
      case (PADDR)
        `CCS_ADDR_SETUP: setup_word <= PWDATA[11:0];
        `CCS_ADDR_C0: sense_c0 <= PWDATA[15:0];
        `CCS_ADDR_C1: sense_c1 <= PWDATA[15:0];
        `CCS_ADDR_TQTY: temp_qty <= PWDATA[15:0];
        `CCS_ADDR_TCAL: temp_cal <= PWDATA[15:0];
        `CCS_ADDR_MASK: mask <= PWDATA[3:0];
        default: mask <= mask;
      endcase
    end
  end

  // Operands for the ratio, from the settings latched at start
  always_comb begin
    next_coff = cap_scale(meas_temp ? 2'h0 : rs, zs);
    if (meas_temp) begin
      next_den = cap_scale(2'h0, rf);
    end else if (diff) begin
      next_den = {1'h0, sense_c0} + {1'h0, sense_c1};
    end else if (rf == 3'h0) begin
      next_den = {1'h0, sense_c1};
    end else begin
      next_den = cap_scale(rs, rf);
    end
    next_num = {2'h0, meas_temp ? temp_qty : sense_c0} - {1'h0, next_coff};
    next_shift = meas_temp ? 5'he : {2'h0, resw, 1'b0} + 5'h8;
    next_dividend = {16'h0, numer[15:0]} << next_shift;
  end

  // Result clamping once the quotient is ready
  always_comb begin
    fs = meas_temp ? 14'h3fff : full_scale(resw);
    next_lo = numer[17];
    next_hi = !numer[17] && div_q > {18'h0, fs};
    if (next_lo) begin
      next_code = 14'h0;
    end else if (next_hi) begin
      next_code = fs;
    end else begin
      next_code = div_q[13:0];
    end
    tsum = {3'h0, next_code} + {temp_cal[15], temp_cal};
    if (tsum[16]) begin
      next_temp = 14'h0;
    end else if (tsum[15:14] != 2'h0) begin
      next_temp = 14'h3fff;
    end else begin
      next_temp = tsum[13:0];
    end
  end

  // Conversion sequence
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      active <= `CCS_SETUP_RST;
      meas_temp <= 1'b0;
      per_cnt <= 4'h0;
      numer <= 18'h0;
      denom <= 17'h0;
      div_start <= 1'b0;
    end else begin
      div_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_cap || start_temp) begin
            active <= setup_word;
            meas_temp <= start_temp;
            per_cnt <= 4'h0;
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (exc_tick) begin
            per_cnt <= per_cnt + 4'h1;
            if (per_cnt == `CCS_CONV_PERIODS - 4'h1) begin
              state <= ST_CALC;
            end
          end
        end
        ST_CALC: begin
          numer <= next_num;
          denom <= next_den;
          state <= ST_DIV;
          div_start <= 1'b1;
        end
        ST_DIV: begin
          if (div_start) begin
            state <= ST_DIV;
          end else if (div_done) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Results land in the register of the measured quantity only
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      raw_capacitance_code <= 14'h0;
      temp_reading <= 14'h0;
    end else if (state == ST_DIV && div_done) begin
      if (meas_temp) begin
        temp_reading <= next_temp;
      end else begin
        raw_capacitance_code <= next_code;
      end
    end
  end

  always_comb begin
    stat_set = 4'h0;
    if (state == ST_DIV && div_done) begin
      stat_set[`CCS_ST_CAP] = !meas_temp;
      stat_set[`CCS_ST_TEMP] = meas_temp;
      stat_set[`CCS_ST_LO] = next_lo;
      stat_set[`CCS_ST_HI] = next_hi;
    end
  end

  // Read clears only bits that were shown, so a new event is never lost
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      status <= 4'h0;
      IRQ <= 1'b0;
    end else begin
      if (access && !PWRITE && PADDR == `CCS_ADDR_STAT) begin
        status <= (status & ~PRDATA[3:0]) | stat_set;
      end else begin
        status <= status | stat_set;
      end
      IRQ <= |(status & mask);
    end
  end

  // Ready level stands from completion of a capacitance conversion until the next start
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ready_flag <= 1'b0;
    end else if (state == ST_DONE && !meas_temp) begin
      ready_flag <= 1'b1;
    end else if (state == ST_IDLE && (start_cap || start_temp)) begin
      ready_flag <= 1'b0;
    end
  end

  // First-order density modulator of the code scaled to 14 bits
  assign dens_in = raw_capacitance_code << (4'h6 - {1'b0, resw, 1'b0});
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      dens_acc <= 15'h0;
      dens_bit <= 1'b0;
    end else begin
      dens_acc <= {1'b0, dens_acc[13:0]} + {1'b0, dens_in};
      dens_bit <= dens_acc[14];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      READY_PDM <= 1'b0;
      EXC_OUT <= 1'b0;
    end else begin
      READY_PDM <= active[`CCS_PDM_BIT] ? dens_bit : ready_flag;
      EXC_OUT <= exc;
    end
  end

  ccs_excite u_excite (
    .clk(CLK),
    .rstn(RSTN),
    .range_sel(rs),
    .exc(exc),
    .tick(exc_tick)
  );

  ccs_divider u_divider (
    .clk(CLK),
    .rstn(RSTN),
    .start(div_start),
    .dividend(next_dividend),
    .divisor(denom),
    .done(div_done),
    .quotient(div_q)
  );

  sequence s_conv_start;
    state == ST_IDLE && (start_cap || start_temp);
  endsequence
  sequence s_result;
    state == ST_DIV && div_done;
  endsequence

  property p_latch;
    @(posedge CLK) disable iff (!RSTN)
    s_conv_start |=> active == $past(setup_word) && state == ST_SAMPLE;
  endproperty
  a_latch: assert property (p_latch) else $error("setup word not latched");

  property p_conv_time;
    @(posedge CLK) disable iff (!RSTN)
    s_conv_start |-> ##[40:120] state == ST_DONE;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion did not end");

  property p_clamp_lo;
    @(posedge CLK) disable iff (!RSTN)
    s_result ##0 (!meas_temp && numer[17]) |=> raw_capacitance_code == 14'h0 && status[2];
  endproperty
  a_clamp_lo: assert property (p_clamp_lo) else $error("negative ratio not zero");

  property p_clamp_hi;
    @(posedge CLK) disable iff (!RSTN)
    s_result ##0 (!meas_temp && next_hi) |=> raw_capacitance_code == full_scale(resw);
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("ratio over one not full scale");

  property p_width8;
    @(posedge CLK) disable iff (!RSTN)
    s_result ##0 (!meas_temp && resw == 2'h0) |=> raw_capacitance_code[13:8] == 6'h00;
  endproperty
  a_width8: assert property (p_width8) else $error("8-bit code exceeds width");

  property p_den_int;
    @(posedge CLK) disable iff (!RSTN)
    (state == ST_CALC && !meas_temp && !diff && rf != 3'h0) |=> denom == cap_scale(rs, rf);
  endproperty
  a_den_int: assert property (p_den_int) else $error("internal reference wrong");

  property p_den_diff;
    @(posedge CLK) disable iff (!RSTN)
    (state == ST_CALC && !meas_temp && diff) |=>
      denom == $past({1'h0, sense_c0} + {1'h0, sense_c1});
  endproperty
  a_den_diff: assert property (p_den_diff) else $error("differential sum wrong");

  property p_temp_mux;
    @(posedge CLK) disable iff (!RSTN)
    s_result ##0 meas_temp |=> $stable(raw_capacitance_code) && status[1];
  endproperty
  a_temp_mux: assert property (p_temp_mux) else $error("temperature hit cap code");

  property p_ready_pad;
    @(posedge CLK) disable iff (!RSTN)
    (state == ST_DONE && !meas_temp && !active[`CCS_PDM_BIT]) |=> ##1 READY_PDM;
  endproperty
  a_ready_pad: assert property (p_ready_pad) else $error("ready not on pad");
endmodule

// file: verif/ccs_sensor_model.sv
// Sensor element model that measures the excitation period on its reference plate
`timescale 1ns/10ps
module ccs_sensor_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic exc,
  output logic [7:0] period
);
  logic exc_q;
  logic [7:0] cnt;

  // Only whole periods are reported, so a range change shows after one full cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      exc_q <= 1'b0;
      cnt <= 8'h00;
      period <= 8'h00;
    end else begin
      exc_q <= exc;
      if (exc && !exc_q) begin
        period <= cnt;
        cnt <= 8'h01;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule

// file: verif/ccs_top_test.sv
// Self-checking bench for the converter setup block over its register bus
`timescale 1ns/10ps
`include "ccs_defines.svh"
module ccs_top_test import ccs_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic exc_out;
  logic ready_pdm;
  logic [7:0] period;
  logic [31:0] rd;
  logic err;
  logic [15:0] e;
  int n_fail = 0;
  int n_tests = 0;
  int ones;
  logic [11:0] su [7] = '{12'h039, 12'h258, 12'h480, 12'h7c0, 12'h63a, 12'h608, 12'hfc0};
  int c0s [7] = '{500, 1000, 3000, 10000, 100, 500, 10000};
  int c1s [7] = '{0, 0, 10000, 15000, 0, 0, 10000};

  always #5 clk = ~clk;

  ccs_top DUT (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .EXC_OUT(exc_out), .READY_PDM(ready_pdm)
  );

  ccs_sensor_model u_sensor (.clk(clk), .rstn(rstn), .exc(exc_out), .period(period));

  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Request held until ready is seen high; a hang is left to the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk_val(what, exp, rd);
  endtask

  task automatic wait_idle();
    do apb(1'b0, `CCS_ADDR_CTRL, 32'h0); while (rd[0] !== 1'b0);
  endtask

  // Returns clamp high, clamp low and the 14-bit code
  function automatic logic [15:0] model(input logic [11:0] s, input int c0, input int c1);
    int cm, den, num, q, w, full;
    w = 8 + 2 * int'(s[10:9]);
    full = (1 << w) - 1;
    cm = 144 << (2 * int'(s[7:6]));
    den = s[8] ? c0 + c1 : (s[5:3] == 3'h0 ? c1 : cm * int'(s[5:3]));
    num = c0 - cm * int'(s[2:0]);
    if (num < 0) return 16'h4000;
    q = (den == 0) ? full + 1 : (num << w) / den;
    if (q > full) return {2'b10, full[13:0]};
    return {2'b00, q[13:0]};
  endfunction

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rchk(`CCS_ADDR_SETUP, 32'h638, "setup");
    rchk(`CCS_ADDR_RAW, 32'h0, "raw");
    rchk(`CCS_ADDR_STAT, 32'h0, "status");
    chk_bit("irq", 1'b0, irq);
    apb(1'b0, 8'h28, 32'h0);
    chk_bit("pslverr", 1'b1, err);
    chk_val("prdata", 32'h0, rd);
    wr(`CCS_ADDR_TQTY, 32'd500);
    wr(`CCS_ADDR_TCAL, 32'd5);
    wr(`CCS_ADDR_CTRL, 32'h2);
    wait_idle();
    rchk(`CCS_ADDR_TEMP, 32'h1fc3, "temp");
    rchk(`CCS_ADDR_RAW, 32'h0, "raw");
    chk_bit("irq", 1'b0, irq);
    wr(`CCS_ADDR_MASK, 32'hf);
    repeat (2) @(posedge clk);
    chk_bit("irq", 1'b1, irq);
    rchk(`CCS_ADDR_STAT, 32'h2, "status");
    repeat (2) @(posedge clk);
    chk_bit("irq", 1'b0, irq);
    // Covers every range and width, external reference, differential, both clamps and density pad
    for (int i = 0; i < 7; i++) begin
      wr(`CCS_ADDR_SETUP, {20'h0, su[i]});
      wr(`CCS_ADDR_C0, 32'(c0s[i]));
      wr(`CCS_ADDR_C1, 32'(c1s[i]));
      wr(`CCS_ADDR_CTRL, 32'h1);
      if (i == 0) begin
        wr(`CCS_ADDR_CTRL, 32'h2);
      end
      wait_idle();
      e = model(su[i], c0s[i], c1s[i]);
      chk_bit("irq", 1'b1, irq);
      if (su[i][11]) begin
        // Half scale carries out of the accumulator on every other cycle
        ones = 0;
        repeat (16) begin
          @(posedge clk);
          ones += int'(ready_pdm);
        end
        chk_val("density", 32'd8, 32'(ones));
      end else begin
        chk_bit("ready", 1'b1, ready_pdm);
      end
      rchk(`CCS_ADDR_RAW, {18'h0, e[13:0]}, "raw");
      rchk(`CCS_ADDR_STAT, {28'h0, e[15], e[14], 2'b01}, "status");
      chk_val("period", {24'h0, 8'h02 << su[i][7:6]}, {24'h0, period});
      if (i == 0) begin
        rchk(`CCS_ADDR_TEMP, 32'h1fc3, "temp");
      end
    end
    wr(`CCS_ADDR_RAW, 32'h1234);
    rchk(`CCS_ADDR_RAW, 32'h2000, "raw");
    end_sim();
  end

  initial begin
    #300000;
    n_fail++;
    end_sim();
  end
endmodule
